/* File: rtl/gcd_pkg.sv */
package gcd_pkg;

    // pin counts of the two ports
    localparam int PC_PINS      = 21;
    localparam int PD_PINS      = 8;
    localparam int PC_HIGH_BITS = 5;
    localparam int PC_LOW_BITS  = 16;
    localparam int ALL_PINS     = PC_PINS + PD_PINS;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // register indices on the plain register port
    localparam logic [ADDR_W-1:0] ADDR_PC_HIGH = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PC_LOW  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PD_LOW  = 4'h2;

    // field positions
    localparam int PC_HIGH_LSB = 16;
    localparam int PC_HIGH_MSB = 20;
    localparam int PD_MSB      = 7;

    // reset values and writable masks
    localparam logic [DATA_W-1:0]  REG_RESET    = 16'h0000;
    localparam logic [PC_PINS-1:0] PC_RESET     = 21'h000000;
    localparam logic [PD_PINS-1:0] PD_RESET     = 8'h00;
    localparam logic [DATA_W-1:0]  PC_HIGH_MASK = 16'h001F;
    localparam logic [DATA_W-1:0]  PD_MASK      = 16'h00FF;
    localparam logic [DATA_W-1:0]  RD_IDLE      = 16'h0000;

    // per-pin selections from the pin function controller
    typedef struct packed {
        logic [PC_PINS-1:0] dir;   // 1 general output, 0 general input
        logic [PC_PINS-1:0] gpio;  // 1 general port, 0 other function
    } gcd_pc_mode_s;

    typedef struct packed {
        logic [PD_PINS-1:0] dir;
        logic [PD_PINS-1:0] gpio;
    } gcd_pd_mode_s;

    // register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } gcd_req_s;

endpackage

/* File: rtl/gcd_port_data.sv */
// Functional notes
// - first port has 21 pins; high reg bits 4..0 are pins 20..16, low reg pins 15..0.
// - first port data registers are 16-bit read/write, one bit per pin in order.
// - first port high register bits 15..5 read zero; software writes zero.
// - direction 1 (general output) drives the written data bit onto the pin.
// - general output pins read back the stored register bit, not the pin.
// - direction 0 (general input) pins read the current pin level.
// - general input pins accept writes but the pin is not driven.
// - other-function pins read the register bit and writes never drive the pin.
// - second port has 8 pins in bits 7..0 of one 16-bit read/write register.
// - second port bits 15..8 read zero; software writes only zero.
// - second port behaves like the first in input, output and other-function modes.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module gcd_port_data
    import gcd_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // register port
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire logic [DATA_W-1:0]  wr_data,
    input  wire logic               wr_strobe,
    input  wire logic               rd_strobe,
    output logic      [DATA_W-1:0]  rd_data,
    // pin function controller selections
    input  wire gcd_pc_mode_s       pc_mode,
    input  wire gcd_pd_mode_s       pd_mode,
    // first port pins
    input  wire logic [PC_PINS-1:0] pc_pin_in,
    output logic      [PC_PINS-1:0] pc_pin_out,
    output logic      [PC_PINS-1:0] pc_pin_oe_n,
    // second port pins
    input  wire logic [PD_PINS-1:0] pd_pin_in,
    output logic      [PD_PINS-1:0] pd_pin_out,
    output logic      [PD_PINS-1:0] pd_pin_oe_n
);

    gcd_req_s           req;
    logic [PC_PINS-1:0] pc_data_reg;
    logic [PC_PINS-1:0] pc_data_next;
    logic [PD_PINS-1:0] pd_data_reg;
    logic [PD_PINS-1:0] pd_data_next;
    logic [ALL_PINS-1:0] pin_sync;
    logic [PC_PINS-1:0] pc_pin_sync;
    logic [PD_PINS-1:0] pd_pin_sync;
    logic [PC_PINS-1:0] pc_in_sel;
    logic [PD_PINS-1:0] pd_in_sel;
    logic [PC_PINS-1:0] pc_view;
    logic [PD_PINS-1:0] pd_view;
    logic [DATA_W-1:0]  rd_next;

    assign req.wr    = wr_strobe;
    assign req.rd    = rd_strobe;
    assign req.addr  = addr;
    assign req.wdata = wr_data;

    // pins come from outside the clock domain
    gcd_sync2 #(
        .WIDTH    (ALL_PINS)
    ) u_pin_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({pd_pin_in, pc_pin_in}),
        .sync_out (pin_sync)
    );

    assign pc_pin_sync = pin_sync[PC_PINS-1:0];
    assign pd_pin_sync = pin_sync[ALL_PINS-1:PC_PINS];

    // a pin reads back its level only as a general input
    assign pc_in_sel = pc_mode.gpio & ~pc_mode.dir;
    assign pd_in_sel = pd_mode.gpio & ~pd_mode.dir;

    // per-bit read view: pin level for inputs, stored bit otherwise
    genvar gi;
    generate
        for (gi = 0; gi < ALL_PINS; gi++) begin : g_view
            if (gi < PC_PINS) begin : g_pc
                assign pc_view[gi] = pc_in_sel[gi] ? pc_pin_sync[gi]
                                                   : pc_data_reg[gi];
            end else begin : g_pd
                assign pd_view[gi-PC_PINS] = pd_in_sel[gi-PC_PINS]
                                           ? pd_pin_sync[gi-PC_PINS]
                                           : pd_data_reg[gi-PC_PINS];
            end
        end
    endgenerate

    // write decode; every mode stores the bit, only the pin enable differs
    always_comb begin
        pc_data_next = pc_data_reg;
        pd_data_next = pd_data_reg;
        if (req.wr) begin
            case (req.addr)
                ADDR_PC_HIGH: begin
                    pc_data_next[PC_HIGH_MSB:PC_HIGH_LSB] =
                        req.wdata[PC_HIGH_BITS-1:0];
                end
                ADDR_PC_LOW: begin
                    pc_data_next[PC_LOW_BITS-1:0] = req.wdata;
                end
                ADDR_PD_LOW: begin
                    pd_data_next = req.wdata[PD_MSB:0];
                end
                default: begin
                    pc_data_next = pc_data_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pc_data_reg <= PC_RESET;
        end else begin
            pc_data_reg <= pc_data_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pd_data_reg <= PD_RESET;
        end else begin
            pd_data_reg <= pd_data_next;
        end
    end

    // read mux; reserved bits are never sourced from storage
    always_comb begin
        rd_next = RD_IDLE;
        if (req.rd) begin
            case (req.addr)
                ADDR_PC_HIGH: begin
                    rd_next = PC_HIGH_MASK
                            & {{(DATA_W-PC_HIGH_BITS){1'b0}},
                               pc_view[PC_HIGH_MSB:PC_HIGH_LSB]};
                end
                ADDR_PC_LOW: begin
                    rd_next = pc_view[PC_LOW_BITS-1:0];
                end
                ADDR_PD_LOW: begin
                    rd_next = PD_MASK & {{(DATA_W-PD_PINS){1'b0}}, pd_view};
                end
                default: begin
                    rd_next = RD_IDLE;
                end
            endcase
        end
    end

    // read data stand only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= RD_IDLE;
        end else begin
            rd_data <= rd_next;
        end
    end

    // the data registers themselves are the pin output flip-flops
    assign pc_pin_out = pc_data_reg;
    assign pd_pin_out = pd_data_reg;

    // drive only general outputs; an other-function pin belongs to its peripheral
    always_ff @(posedge clk) begin
        if (rst) begin
            pc_pin_oe_n <= {PC_PINS{1'b1}};
        end else begin
            pc_pin_oe_n <= ~(pc_mode.gpio & pc_mode.dir);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pd_pin_oe_n <= {PD_PINS{1'b1}};
        end else begin
            pd_pin_oe_n <= ~(pd_mode.gpio & pd_mode.dir);
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge clk);
    endclocking

    a_pc_high_store: assert property (
        disable iff (rst)
        (wr_strobe && addr == ADDR_PC_HIGH)
        |=> pc_data_reg[PC_HIGH_MSB:PC_HIGH_LSB] == $past(wr_data[PC_HIGH_BITS-1:0])
            && pc_data_reg[PC_LOW_BITS-1:0] == $past(pc_data_reg[PC_LOW_BITS-1:0])
    ) else $error("high register write did not land in pins 20..16");

    a_pc_low_store: assert property (
        disable iff (rst)
        (wr_strobe && addr == ADDR_PC_LOW)
        |=> pc_data_reg[PC_LOW_BITS-1:0] == $past(wr_data)
            && pc_data_reg[PC_HIGH_MSB:PC_HIGH_LSB]
               == $past(pc_data_reg[PC_HIGH_MSB:PC_HIGH_LSB])
    ) else $error("low register write did not land in pins 15..0");

    a_pc_high_reserved: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PC_HIGH) |=> rd_data[DATA_W-1:PC_HIGH_BITS] == '0
    ) else $error("reserved high bits of first port read nonzero");

    a_out_pin_drive: assert property (
        disable iff (rst)
        !$past(rst) |-> pc_pin_oe_n == ~$past(pc_mode.gpio & pc_mode.dir)
                        && pc_pin_out == pc_data_reg
    ) else $error("general output pin not driven from its data bit");

    a_out_read_reg: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PC_LOW)
        |=> (rd_data & ~$past(pc_in_sel[PC_LOW_BITS-1:0]))
            == ($past(pc_data_reg[PC_LOW_BITS-1:0]) & ~$past(pc_in_sel[PC_LOW_BITS-1:0]))
    ) else $error("output or other-function bit did not read register value");

    a_in_read_pin: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PC_LOW)
        |=> (rd_data & $past(pc_in_sel[PC_LOW_BITS-1:0]))
            == ($past(pc_pin_sync[PC_LOW_BITS-1:0]) & $past(pc_in_sel[PC_LOW_BITS-1:0]))
    ) else $error("general input bit did not read pin level");

    a_in_write_float: assert property (
        disable iff (rst)
        !$past(rst)
        |-> (pc_pin_oe_n & $past(pc_in_sel)) == $past(pc_in_sel)
    ) else $error("general input pin is being driven");

    a_other_func_float: assert property (
        disable iff (rst)
        !$past(rst)
        |-> (pc_pin_oe_n & ~$past(pc_mode.gpio)) == ~$past(pc_mode.gpio)
            && (pd_pin_oe_n & ~$past(pd_mode.gpio)) == ~$past(pd_mode.gpio)
    ) else $error("other-function pin is being driven");

    a_pd_store: assert property (
        disable iff (rst)
        (wr_strobe && addr == ADDR_PD_LOW) |=> pd_data_reg == $past(wr_data[PD_MSB:0])
    ) else $error("second port write did not land in bits 7..0");

    a_pd_reserved: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PD_LOW) |=> rd_data[DATA_W-1:PD_PINS] == '0
    ) else $error("reserved bits of second port read nonzero");

    a_pd_read_view: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PD_LOW)
        |=> rd_data[PD_MSB:0] == (($past(pd_pin_sync) & $past(pd_in_sel))
                                | ($past(pd_data_reg) & ~$past(pd_in_sel)))
    ) else $error("second port read view is wrong");

    a_reset_clears: assert property (
        rst |=> pc_data_reg == PC_RESET && pd_data_reg == PD_RESET
                && rd_data == RD_IDLE && &pc_pin_oe_n && &pd_pin_oe_n
    ) else $error("reset did not clear data and release pins");

    a_read_one_cycle: assert property (
        disable iff (rst)
        !rd_strobe |=> rd_data == RD_IDLE
    ) else $error("read data stood beyond its cycle");

    // high register view built from the rules, not from the read mux
    a_pc_high_view: assert property (
        disable iff (rst)
        (rd_strobe && addr == ADDR_PC_HIGH)
        |=> rd_data[PC_HIGH_BITS-1:0]
            == (($past(pc_pin_sync[PC_HIGH_MSB:PC_HIGH_LSB])
                 & $past(pc_in_sel[PC_HIGH_MSB:PC_HIGH_LSB]))
               | ($past(pc_data_reg[PC_HIGH_MSB:PC_HIGH_LSB])
                 & ~$past(pc_in_sel[PC_HIGH_MSB:PC_HIGH_LSB])))
    ) else $error("first port high register read view is wrong");

    a_pd_out_drive: assert property (
        disable iff (rst)
        !$past(rst) |-> pd_pin_oe_n == ~$past(pd_mode.gpio & pd_mode.dir)
                        && pd_pin_out == pd_data_reg
    ) else $error("second port output pin not driven from its data bit");

    a_pd_in_float: assert property (
        disable iff (rst)
        !$past(rst)
        |-> (pd_pin_oe_n & $past(pd_in_sel)) == $past(pd_in_sel)
    ) else $error("second port input pin is being driven");

    // unmapped indices must leave every data bit alone
    a_unmapped_write: assert property (
        disable iff (rst)
        (wr_strobe && addr > ADDR_PD_LOW)
        |=> $stable(pc_data_reg) && $stable(pd_data_reg)
    ) else $error("unmapped write changed a data register");

    a_unmapped_read: assert property (
        disable iff (rst)
        (rd_strobe && addr > ADDR_PD_LOW) |=> rd_data == RD_IDLE
    ) else $error("unmapped read returned nonzero data");

    a_idle_hold: assert property (
        disable iff (rst)
        !wr_strobe |=> $stable(pc_data_reg) && $stable(pd_data_reg)
    ) else $error("data register changed without a write");

    a_pd_write_only: assert property (
        disable iff (rst)
        (wr_strobe && addr == ADDR_PD_LOW) |=> $stable(pc_data_reg)
    ) else $error("second port write disturbed the first port");

    a_pc_write_only: assert property (
        disable iff (rst)
        (wr_strobe && (addr == ADDR_PC_HIGH || addr == ADDR_PC_LOW))
        |=> $stable(pd_data_reg)
    ) else $error("first port write disturbed the second port");

    // the two register halves map the pins without overlap
    a_pc_low_only: assert property (
        disable iff (rst)
        (wr_strobe && addr == ADDR_PC_LOW)
        |=> pc_pin_out[PC_HIGH_MSB:PC_HIGH_LSB]
            == $past(pc_pin_out[PC_HIGH_MSB:PC_HIGH_LSB])
    ) else $error("low register write reached pins 20..16");

endmodule

/* File: rtl/gcd_sync2.sv */
`timescale 1ns/100ps
module gcd_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

/* File: tb/gcd_pin_model.sv */
`timescale 1ns/100ps
module gcd_pin_model #(
    parameter int W = 8
) (
    // block side of the pads
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    // outside source, always driving weakly
    input  wire logic [W-1:0] ext_level,
    output logic      [W-1:0] pin_level
);
    // the block wins where it drives; elsewhere the outside source sets the line,
    // so an undriven pin never shows a stale copy of the block's own value
    assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

/* File: tb/gpio_port_c_d_data_tb_top.sv */
`timescale 1ns/100ps
module gpio_port_c_d_data_tb_top
    import gcd_pkg::*;
;
    logic               clk       = 1'b0;
    logic               rst       = 1'b1;
    logic [ADDR_W-1:0]  addr      = '0;
    logic [DATA_W-1:0]  wr_data   = '0;
    logic               wr_strobe = 1'b0;
    logic               rd_strobe = 1'b0;
    logic [DATA_W-1:0]  rd_data;
    gcd_pc_mode_s       pc_mode   = '0;
    gcd_pd_mode_s       pd_mode   = '0;
    logic [PC_PINS-1:0] pc_ext    = '0;
    logic [PC_PINS-1:0] pc_lvl;
    logic [PC_PINS-1:0] pc_out;
    logic [PC_PINS-1:0] pc_oe_n;
    logic [PD_PINS-1:0] pd_ext    = '0;
    logic [PD_PINS-1:0] pd_lvl;
    logic [PD_PINS-1:0] pd_out;
    logic [PD_PINS-1:0] pd_oe_n;
    logic [DATA_W-1:0]  rv;
    int                 errors     = 0;
    int                 num_checks = 0;

    always #10 clk = ~clk;

    gcd_port_data dut_u (
        .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .pc_mode(pc_mode), .pd_mode(pd_mode),
        .pc_pin_in(pc_lvl), .pc_pin_out(pc_out), .pc_pin_oe_n(pc_oe_n),
        .pd_pin_in(pd_lvl), .pd_pin_out(pd_out), .pd_pin_oe_n(pd_oe_n)
    );
    gcd_pin_model #(.W(PC_PINS)) pc_pins_u (
        .pin_out(pc_out), .pin_oe_n(pc_oe_n), .ext_level(pc_ext), .pin_level(pc_lvl)
    );
    gcd_pin_model #(.W(PD_PINS)) pd_pins_u (
        .pin_out(pd_out), .pin_oe_n(pd_oe_n), .ext_level(pd_ext), .pin_level(pd_lvl)
    );

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 d = rd_data;
    endtask

    // read follows the write closely, before a driven pin could reach the read path
    task automatic pc_run(input logic [PC_PINS-1:0] dir, gpio, ext, d);
        logic [PC_PINS-1:0] view;
        @(posedge clk);
        pc_mode <= '{dir: dir, gpio: gpio};
        pc_ext  <= ext;
        view = (gpio & ~dir & ext) | (~(gpio & ~dir) & d);
        reg_wr(ADDR_PC_LOW, d[15:0]);
        reg_rd(ADDR_PC_LOW, rv);
        chk("pc low", {16'h0, view[15:0]}, {16'h0, rv});
        reg_wr(ADDR_PC_HIGH, {11'h000, d[20:16]});
        reg_rd(ADDR_PC_HIGH, rv);
        chk("pc high", {27'h0, view[20:16]}, {16'h0, rv});
        chk("pc oe_n", {11'h0, ~(gpio & dir)}, {11'h0, pc_oe_n});
        chk("pc level", {11'h0, (gpio & dir & d) | (~(gpio & dir) & ext)}, {11'h0, pc_lvl});
    endtask

    task automatic pd_run(input logic [PD_PINS-1:0] dir, gpio, ext, d);
        logic [PD_PINS-1:0] view;
        @(posedge clk);
        pd_mode <= '{dir: dir, gpio: gpio};
        pd_ext  <= ext;
        view = (gpio & ~dir & ext) | (~(gpio & ~dir) & d);
        reg_wr(ADDR_PD_LOW, {8'h00, d});
        reg_rd(ADDR_PD_LOW, rv);
        chk("pd data", {24'h0, view}, {16'h0, rv});
        chk("pd oe_n", {24'h0, ~(gpio & dir)}, {24'h0, pd_oe_n});
        chk("pd level", {24'h0, (gpio & dir & d) | (~(gpio & dir) & ext)}, {24'h0, pd_lvl});
    endtask

    task automatic sc_reset();
        reg_rd(ADDR_PC_HIGH, rv);
        chk("reset high", 32'h0, {16'h0, rv});
        reg_rd(ADDR_PC_LOW, rv);
        chk("reset low", 32'h0, {16'h0, rv});
        reg_rd(ADDR_PD_LOW, rv);
        chk("reset pd", 32'h0, {16'h0, rv});
        chk("reset oe_n", 32'h1FFFFFFF, {3'h0, pd_oe_n, pc_oe_n});
    endtask

    task automatic sc_port_c();
        pc_run('1, '1, 21'h0A5A3C, 21'h15A5C3);
        pc_run('0, '1, 21'h0F0F0F, 21'h1E1E1E);
        pc_run('1, '0, 21'h1FFFFF, 21'h00A50A);
        pc_run(21'h0F0F0F, 21'h1C71C7, 21'h13579B, 21'h0EDCBA);
    endtask

    task automatic sc_port_d();
        pd_run('1, '1, 8'h3C, 8'hC3);
        pd_run('0, '1, 8'h96, 8'h5A);
        pd_run('1, '0, 8'hFF, 8'h24);
        pd_run(8'h33, 8'h5A, 8'hE1, 8'h7E);
    endtask

    // unmapped places neither store nor answer, and read data fall back to zero
    task automatic sc_unmapped();
        reg_wr(4'h3, 16'hFFFF);
        reg_rd(4'h3, rv);
        chk("unmapped 3", 32'h0, {16'h0, rv});
        reg_rd(4'hF, rv);
        chk("unmapped F", 32'h0, {16'h0, rv});
        reg_rd(ADDR_PD_LOW, rv);
        chk("pd kept", 32'h76, {16'h0, rv});
        @(posedge clk);
        #1 chk("rd idle", 32'h0, {16'h0, rd_data});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        sc_reset();
        sc_port_c();
        sc_port_d();
        sc_unmapped();
        final_report();
    end

    // a hang costs at most 100k cycles
    initial begin
        #2000000;
        errors++;
        final_report();
    end
endmodule
